// ===== rtl/rsse_exec.sv
// Purpose: executes rotate-right, sleep and subtract for the core
// Assumes: one instruction offered per cycle with instr_valid, operands valid alongside
// Notes: results appear one cycle later as registered write strobes
// Behaviour
// - rotate right through carry, only carry changes
// - rotate result to accumulator if d=0, file otherwise
// - sleep stops oscillator and enters low power
// - sleep sets time-out, clears power-down and watchdog
// - subtract file minus accumulator, update carry, half_carry, zero
`timescale 1ns/1ps
`include "rsse_consts.svh"

module rsse_exec
	import rsse_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        instr_valid,     // instruction word present this cycle
	input  wire logic [11:0] instr,           // instruction word
	input  wire logic [7:0]  file_data,       // contents of addressed file register
	input  wire logic [7:0]  acc_data,        // accumulator contents
	input  wire logic        carry_in,        // current carry flag
	output logic             acc_we,          // write strobe for accumulator
	output logic [7:0]       acc_wdata,       // accumulator write data
	output logic             file_we,         // write strobe for file register
	output logic [4:0]       file_addr,       // file register address to write
	output logic [7:0]       file_wdata,      // file register write data
	output logic             carry_we,        // carry flag update strobe
	output logic             carry_out,       // new carry
	output logic             half_carry_we,   // half_carry update strobe
	output logic             half_carry,      // new half_carry
	output logic             zero_we,         // zero flag update strobe
	output logic             zero_out,        // new zero flag
	output logic             time_out_we,     // time_out_flag update strobe
	output logic             time_out_flag,   // new time_out_flag
	output logic             power_down_we,   // power_down_flag update strobe
	output logic             power_down_flag, // new power_down_flag
	output logic             watchdog_clear,  // clear watchdog_counter and prescaler
	output logic             osc_stop,        // stop main oscillator
	output logic             sleep_state      // low-power state entered, held
);

	// ********************************
	// decode
	// ********************************
	wire logic [5:0] opc   = instr[`RSSE_OP_HI:`RSSE_OP_LO];   // opcode field
	wire logic       dest  = instr[`RSSE_DEST_BIT];            // destination select
	wire logic [4:0] faddr = instr[`RSSE_ADDR_HI:`RSSE_ADDR_LO]; // file address
	rsse_op_t        op;                                         // decoded kind

	assign op = !instr_valid                       ? rsse_op_none  :
	            (opc == `RSSE_OPC_ROTR)            ? rsse_op_rotr  :
	            (instr == `RSSE_SLEEP_WORD)        ? rsse_op_sleep :
	            (opc == `RSSE_OPC_SUB)             ? rsse_op_sub   : rsse_op_none;

	// ********************************
	// datapath
	// ********************************
	// rotate right: old carry into top, bottom bit to carry
	wire logic [7:0] rot_res = {carry_in, file_data[`RSSE_MSB:`RSSE_ROT_LO]};
	wire logic       rot_c   = file_data[`RSSE_LSB];
	// subtract by adding two's complement; carry out is inverted borrow
	// the ninth bit is the carry out, so no separate compare is needed
	wire logic [8:0] sub_full = {1'b0, file_data} + {1'b0, ~acc_data} + `RSSE_ONE9;
	// low nibble done on its own to pick up the half carry
	wire logic [4:0] sub_low  = {1'b0, file_data[`RSSE_NIB_HI:0]} + {1'b0, ~acc_data[`RSSE_NIB_HI:0]}
	                          + `RSSE_ONE5;
	wire logic [7:0] sub_res  = sub_full[`RSSE_MSB:`RSSE_LSB];                  // difference, 8 bits
	wire logic       sub_c    = sub_full[`RSSE_BORROW_BIT];                     // set when no borrow
	wire logic       sub_hc   = sub_low[`RSSE_NIB_CARRY];                       // set when no nibble borrow
	wire logic       is_rot   = (op == rsse_op_rotr);
	wire logic       is_sub   = (op == rsse_op_sub);
	wire logic       is_slp   = (op == rsse_op_sleep);
	wire logic [7:0] res      = is_rot ? rot_res : sub_res;    // result for the destination
	wire logic       wr_any   = is_rot | is_sub;

	// ********************************
	// registered outputs
	// ********************************
	// write strobes and data, one cycle pulses
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_we     <= 1'b0;
			file_we    <= 1'b0;
			acc_wdata  <= `RSSE_ZERO8;
			file_wdata <= `RSSE_ZERO8;
			file_addr  <= `RSSE_ADDR_RST;
		end else begin
			acc_we     <= wr_any & !dest;
			file_we    <= wr_any & dest;
			acc_wdata  <= res;
			file_wdata <= res;
			file_addr  <= faddr;
		end
	end

	// arithmetic flags: rotate touches only carry
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			carry_we      <= 1'b0;
			carry_out     <= 1'b0;
			half_carry_we <= 1'b0;
			half_carry    <= 1'b0;
			zero_we       <= 1'b0;
			zero_out      <= 1'b0;
		end else begin
			carry_we      <= wr_any;
			carry_out     <= is_rot ? rot_c : sub_c;
			half_carry_we <= is_sub;
			half_carry    <= sub_hc;
			zero_we       <= is_sub;
			zero_out      <= (sub_res == `RSSE_ZERO8);
		end
	end

	// sleep effects; pin_change_wake_flag has no output so stays untouched
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			time_out_we     <= 1'b0;
			time_out_flag   <= 1'b0;
			power_down_we   <= 1'b0;
			power_down_flag <= 1'b0;
			watchdog_clear  <= 1'b0;
			osc_stop        <= 1'b0;
			sleep_state     <= 1'b0;
		end else begin
			time_out_we     <= is_slp;
			time_out_flag   <= `RSSE_TO_SLEEP;
			power_down_we   <= is_slp;
			power_down_flag <= `RSSE_PD_SLEEP;
			watchdog_clear  <= is_slp;
			osc_stop        <= is_slp;
			if (is_slp) begin
				sleep_state <= 1'b1;
			end
		end
	end

	// ********************************
	// assertions
	// ********************************
	sequence s_sleep_seen;
		instr_valid && (instr == `RSSE_SLEEP_WORD);
	endsequence
	sequence s_sleep_done;
		time_out_we && time_out_flag && power_down_we && !power_down_flag && watchdog_clear;
	endsequence

	rot_dest_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_rot |=> (acc_we == !$past(dest)) && (file_we == $past(dest)))
		else $error("rotate destination wrong");
	rot_value_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_rot |=> acc_wdata == {$past(carry_in), $past(file_data[`RSSE_MSB:`RSSE_ROT_LO])}
		&& carry_out == $past(file_data[`RSSE_LSB]))
		else $error("rotate value wrong");
	rot_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_rot |=> carry_we && !zero_we && !half_carry_we)
		else $error("rotate touched other flags");
	sleep_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_sleep_seen |=> s_sleep_done)
		else $error("sleep flags wrong");
	sleep_enter_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_sleep_seen |=> osc_stop ##1 sleep_state)
		else $error("sleep not entered");
	sub_value_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_sub |=> (acc_wdata == 8'($past(file_data) - $past(acc_data))) && zero_we && half_carry_we)
		else $error("subtract value wrong");
	sub_borrow_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_sub |=> carry_out == ($past(file_data) >= $past(acc_data)))
		else $error("subtract carry wrong");
	sub_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_sub |=> zero_out == ($past(file_data) == $past(acc_data)))
		else $error("subtract zero wrong");

	// ********************************
	// destination, half carry, quiet-cycle and sleep hold assertions
	// ********************************
	// a taken rotate that goes back to the file register
	sequence s_rot_to_file;
		is_rot && dest;
	endsequence
	// a taken subtract that goes back to the file register
	sequence s_sub_to_file;
		is_sub && dest;
	endsequence
	// a cycle that offers nothing this block executes
	sequence s_refused;
		!is_rot && !is_sub && !is_slp;
	endsequence

	// rotate written back lands at the addressed file register
	rot_file_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_rot_to_file |=> file_addr == $past(faddr)
		&& file_wdata == {$past(carry_in), $past(file_data[`RSSE_MSB:`RSSE_ROT_LO])})
		else $error("rotate file write wrong");

	// subtract picks its destination from the same bit as rotate
	sub_dest_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_sub |=> (acc_we == !$past(dest)) && (file_we == $past(dest)) && carry_we)
		else $error("subtract destination wrong");

	// subtract written back lands at the addressed file register
	sub_file_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_sub_to_file |=> file_addr == $past(faddr)
		&& file_wdata == 8'($past(file_data) - $past(acc_data)))
		else $error("subtract file write wrong");

	// half carry is set when the low nibble needs no borrow
	sub_half_a: assert property (@(posedge mclk) disable iff (!rst_b)
		is_sub |=> half_carry == ($past(file_data[`RSSE_NIB_HI:0]) >= $past(acc_data[`RSSE_NIB_HI:0])))
		else $error("subtract half carry wrong");

	// refused words and idle cycles raise no strobe at all
	refused_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_refused |=> !acc_we && !file_we && !carry_we && !half_carry_we && !zero_we
		&& !time_out_we && !power_down_we && !watchdog_clear && !osc_stop)
		else $error("refused word raised a strobe");

	// sleep touches no data register and no arithmetic flag
	sleep_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
		s_sleep_seen |=> !acc_we && !file_we && !carry_we && !half_carry_we && !zero_we)
		else $error("sleep touched data or flags");

	// once entered, the low-power state is left only through reset
	sleep_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sleep_state |=> sleep_state)
		else $error("sleep state dropped");

endmodule : rsse_exec

// ===== include/rsse_consts.svh
// Purpose: constants for the rotate, sleep and subtract execution block
// Assumes: 12-bit instruction words, 8-bit data
// Notes: definitions only
`ifndef RSSE_CONSTS_SVH
`define RSSE_CONSTS_SVH

`define RSSE_OP_HI       11
`define RSSE_OP_LO       6
`define RSSE_OPC_ROTR    6'h0c
`define RSSE_OPC_SUB     6'h02
`define RSSE_SLEEP_WORD  12'h003
`define RSSE_DEST_BIT    5
`define RSSE_ADDR_HI     4
`define RSSE_ADDR_LO     0
`define RSSE_MSB         7
`define RSSE_LSB         0
`define RSSE_NIB_HI      3
`define RSSE_ZERO8       8'h00
`define RSSE_ROT_LO      1
`define RSSE_ADDR_RST    5'h00
`define RSSE_ONE9        9'h001
`define RSSE_ONE5        5'h01
`define RSSE_BORROW_BIT  8
`define RSSE_NIB_CARRY   4
`define RSSE_TO_SLEEP    1'b1
`define RSSE_PD_SLEEP    1'b0

`endif

// ===== include/rsse_pkg.sv
// Purpose: types for the rotate, sleep and subtract execution block
// Assumes: nothing
// Notes: operation kinds decoded from the instruction word
package rsse_pkg;
	typedef enum logic [1:0] {
		rsse_op_none,
		rsse_op_rotr,
		rsse_op_sleep,
		rsse_op_sub
	} rsse_op_t;
endpackage : rsse_pkg

// ===== tb/rsse_partner.sv
// Purpose: decode stage and register file stand-in for the execution block
// Assumes: the bench offers at most one word per cycle
// Notes: operands are scrambled while no word is offered
`timescale 1ns/1ps
module rsse_partner (
	input  wire logic        req,         // word offered this cycle
	input  wire logic [11:0] word,        // instruction word
	input  wire logic [7:0]  f_val,       // addressed file register
	input  wire logic [7:0]  w_val,       // accumulator
	input  wire logic        c_val,       // carry flag
	output logic             instr_valid, // to block
	output logic [11:0]      instr,       // to block
	output logic [7:0]       file_data,   // to block
	output logic [7:0]       acc_data,    // to block
	output logic             carry_in     // to block
);
	// idle cycles show inverted operands so stale values never pass as valid
	assign instr_valid = req;
	assign instr       = word;
	assign file_data   = req ? f_val : ~f_val;
	assign acc_data    = req ? w_val : ~w_val;
	assign carry_in    = req ? c_val : ~c_val;
endmodule : rsse_partner

// ===== tb/tb_rsse_exec.sv
// Purpose: self-checking bench for the rotate, sleep and subtract block
// Assumes: strobes answer one cycle after the taking edge
// Notes: data outputs are masked by their strobes before comparison
`timescale 1ns/1ps
module tb_rsse_exec;
	import rsse_pkg::*;
	logic        mclk = 0, rst_b = 0, req = 0, c = 0;
	logic [11:0] word = 12'h000;
	logic [7:0]  f = 8'h00, w = 8'h00;
	int          error_cnt = 0, compares = 0, seed = 79, t, k;
	logic [34:0] exp_q[$]; // expected masked strobe vectors
	logic instr_valid, carry_in, acc_we, file_we, carry_we, carry_out, half_carry_we, half_carry, zero_we, zero_out;
	logic time_out_we, time_out_flag, power_down_we, power_down_flag, watchdog_clear, osc_stop, sleep_state;
	logic [11:0] instr;
	logic [7:0]  file_data, acc_data, acc_wdata, file_wdata;
	logic [4:0]  file_addr;
	wire logic [34:0] obs = {acc_we, acc_wdata & {8{acc_we}}, file_we, file_addr & {5{file_we}},
		file_wdata & {8{file_we}}, carry_we, carry_out & carry_we, half_carry_we, half_carry & half_carry_we,
		zero_we, zero_out & zero_we, time_out_we, time_out_flag & time_out_we, power_down_we,
		power_down_flag & power_down_we, watchdog_clear, osc_stop};
	rsse_partner p_u (.req, .word, .f_val(f), .w_val(w), .c_val(c), .instr_valid, .instr, .file_data, .acc_data,
		.carry_in);
	rsse_exec dut_u (.mclk, .rst_b, .instr_valid, .instr, .file_data, .acc_data, .carry_in, .acc_we, .acc_wdata,
		.file_we, .file_addr, .file_wdata, .carry_we, .carry_out, .half_carry_we, .half_carry, .zero_we, .zero_out,
		.time_out_we, .time_out_flag, .power_down_we, .power_down_flag, .watchdog_clear, .osc_stop, .sleep_state);
	// ****************
	// clock and watchdog
	// ****************
	always #12.5 mclk = ~mclk;
	initial begin
		#25000;
		error_cnt++;
		report_and_stop();
	end
	// destination fields: accumulator when the bit is 0, file register otherwise
	function automatic logic [22:0] dst(input logic db, input logic [4:0] a, input logic [7:0] v);
		return {~db, db ? 8'h00 : v, db, db ? a : 5'h00, db ? v : 8'h00};
	endfunction : dst
	task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// offers one word at the falling edge and notes its expected answer
	task automatic issue(input logic [5:0] op, input logic v, input logic eq);
		logic [8:0] d;
		logic [7:0] r;
		@(negedge mclk);
		req = v;
		f = 8'($random(seed));
		w = eq ? f : 8'($random(seed));
		c = 1'($random(seed));
		word = (op == 6'h00) ? 12'h003 : {op, 6'($random(seed))};
		d = {1'b0, f} - {1'b0, w};
		r = (op == 6'h0c) ? {c, f[7:1]} : d[7:0];
		if (v && op == 6'h0c)
			exp_q.push_back({dst(word[5], word[4:0], r), 1'b1, f[0], 10'h000});
		if (v && op == 6'h02)
			exp_q.push_back({dst(word[5], word[4:0], r), 1'b1, ~d[8], 1'b1, f[3:0] >= w[3:0], 1'b1, r == 8'h00, 6'h00});
		if (v && op == 6'h00)
			exp_q.push_back({29'h0, 6'h3b});
	endtask : issue
	// ****************
	// result monitor
	// ****************
	always @(negedge mclk) begin
		if (rst_b && obs !== 35'h0) begin
			if (exp_q.size() == 0)
				chk("spurious strobes", obs, 35'h0);
			else
				chk("strobes", obs, exp_q.pop_front());
		end
	end
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// rotate, subtract, refused words, then a sleep inside back-to-back traffic
	initial begin
		repeat (10) @(negedge mclk);
		rst_b = 1;
		@(negedge mclk);
		chk("sleep_state", {34'h0, sleep_state}, 35'h0);
		for (t = 0; t < 4; t++) begin
			for (k = 0; k < 30; k++)
				case (t)
					0: issue(6'h0c, 1'b1, 1'b0);
					1: issue(6'h02, 1'b1, k % 3 == 0);
					2: issue(k % 3 == 0 ? 6'h0d : (k % 3 == 1 ? 6'h3f : 6'h0c), k % 3 != 2, 1'b0);
					default: issue(k == 5 ? 6'h00 : (k[0] ? 6'h0c : 6'h02), 1'b1, k[1]);
				endcase
			$display("test %0d done", t);
		end
		issue(6'h3f, 1'b0, 1'b0);
		repeat (3) @(negedge mclk);
		chk("sleep_state", {34'h0, sleep_state}, 35'h1);
		chk("pending", 35'(exp_q.size()), 35'h0);
		report_and_stop();
	end
endmodule : tb_rsse_exec
